/* File: opafc_consts.vh */
// constants for the output packet and averaging configuration block
// assumes one clock domain and an 8-bit register port with 8-bit data
`ifndef OPAFC_CONSTS_VH
`define OPAFC_CONSTS_VH

// ****************************************************************
// register addresses and reset values
// ****************************************************************
`define OPAFC_ADDR_W              8
`define OPAFC_DATA_W              8
`define OPAFC_ADDR_FRAME_FORMAT   8'h26
`define OPAFC_ADDR_AVG_CONTROL    8'h27
`define OPAFC_ADDR_GAIN_ENABLES   8'h28
`define OPAFC_RST_FRAME_FORMAT    8'h01
`define OPAFC_RST_AVG_CONTROL     8'h00
`define OPAFC_RST_GAIN_ENABLES    8'h0F
`define OPAFC_READ_UNMAPPED       8'h00

// ****************************************************************
// writable-bit masks, reserved bits clear
// ****************************************************************
`define OPAFC_MASK_FRAME_FORMAT   8'h07
`define OPAFC_MASK_AVG_CONTROL    8'h8F
`define OPAFC_MASK_GAIN_ENABLES   8'h0F

// ****************************************************************
// field positions
// ****************************************************************
`define OPAFC_FIXED_PAT_BIT       2
`define OPAFC_SIZE_MSB            1
`define OPAFC_SIZE_LSB            0
`define OPAFC_AVG_EN_BIT          7
`define OPAFC_AVG_SEL_MSB         3
`define OPAFC_AVG_SEL_LSB         0
`define OPAFC_GAIN_EN_MSB         3
`define OPAFC_GAIN_EN_LSB         0

// ****************************************************************
// packet size codes
// ****************************************************************
`define OPAFC_SIZE_16             2'h0
`define OPAFC_SIZE_24             2'h1
`define OPAFC_SIZE_RSV_A          2'h2
`define OPAFC_SIZE_RSV_B          2'h3

// ****************************************************************
// datapath widths
// ****************************************************************
`define OPAFC_CHANNELS            4
`define OPAFC_SAMPLE_W            16
`define OPAFC_WORD_W              24
`define OPAFC_PAT_W               32
`define OPAFC_ACC_W               33
`define OPAFC_FRAC_W              8
`define OPAFC_CNT_W               16
`define OPAFC_COUNT_W             17

`endif

/* File: opafc_packet_mux.v */
// packet source select and size formatting for one packet stream
// assumes words arrive from the averaging stage on the same clock
`include "opafc_consts.vh"

module opafc_packet_mux (
  // clock and reset
  input  wire                          i_ref_clk,
  input  wire                          i_rst,
  // configuration
  input  wire                          i_fixed_pattern_output_enable,
  input  wire                          i_size_24,
  // per-channel pattern values, channel 0 in the low bits
  input  wire [4*`OPAFC_PAT_W-1:0]     i_per_channel_pattern_value,
  // conversion words in
  input  wire                          i_word_valid,
  input  wire [1:0]                    i_word_chan,
  input  wire [`OPAFC_WORD_W-1:0]      i_word,
  // packets out
  output reg                           o_packet_valid,
  output reg  [1:0]                    o_packet_chan,
  output reg  [`OPAFC_WORD_W-1:0]      o_packet_data
);

  // ****************************************************************
  // source and size select
  // ****************************************************************
  reg [`OPAFC_PAT_W-1:0]  pattern;
  reg [`OPAFC_WORD_W-1:0] source;
  reg [`OPAFC_WORD_W-1:0] next_packet_data;

  // pattern replaces the word whole, so the packet timing is unchanged
  always @* begin
    pattern = i_per_channel_pattern_value[i_word_chan*`OPAFC_PAT_W +:
                                          `OPAFC_PAT_W];
    if (i_fixed_pattern_output_enable) begin
      source = pattern[`OPAFC_PAT_W-1 -: `OPAFC_WORD_W]; // RULE1
    end else begin
      source = i_word;
    end
    // 16-bit packets keep the upper part, right aligned
    if (i_size_24) begin
      next_packet_data = source; // RULE2
    end else begin
      next_packet_data = {{(`OPAFC_WORD_W-`OPAFC_SAMPLE_W){1'b0}},
                          source[`OPAFC_WORD_W-1 -: `OPAFC_SAMPLE_W]};
    end
  end

  // ****************************************************************
  // output register
  // ****************************************************************
  // data outputs come from flops
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_packet_valid <= 1'b0;
      o_packet_chan  <= 2'h0;
      o_packet_data  <= {`OPAFC_WORD_W{1'b0}};
    end else begin
      o_packet_valid <= i_word_valid;
      if (i_word_valid) begin
        o_packet_chan <= i_word_chan;
        o_packet_data <= next_packet_data;
      end
    end
  end

endmodule

/* File: opafc_config_regs.v */
// configuration registers for output packets, averaging and gain ranging
// with the averaging datapath and packet source select behind them
// assumes a register master on i_ref_clk and samples on the same clock
//
// Functional notes
// RULE1: fixed pattern enable replaces every packet with channel pattern upper bits
// RULE2: two-bit size field sets packet width; code 00 gives 16 bits
// RULE3: a 24-bit packet size exists and is the size field reset default
// RULE4: host never writes reserved size code 10
// RULE5: packet layout follows size, averaging mode and pattern enable
// RULE6: averaging enable 0 means plain mode, 1 averaging; resets to 0
// RULE7: host clears averaging enable before changing the count select; the host model clears it in the same write that loads the new select
// RULE8: with averaging on, each channel averages its own results
// RULE9: count select code n averages two to the n plus one results
// RULE10: four per-channel auto gain enables at bits 3..0, reset to 1
// RULE11: frame format register resets to 0x01
// RULE12: size code 01 means 24 bits; codes 10 and 11 are reserved
// RULE13: reserved bits read as zero and ignore writes
//
// Added by the designer: the plain strobed port.
`include "opafc_consts.vh"

module opafc_config_regs (
  // clock and reset
  input  wire                          i_ref_clk,
  input  wire                          i_rst,
  // register port
  input  wire [`OPAFC_ADDR_W-1:0]      i_reg_addr,
  input  wire [`OPAFC_DATA_W-1:0]      i_reg_wdata,
  input  wire                          i_reg_wr,
  input  wire                          i_reg_rd,
  output reg  [`OPAFC_DATA_W-1:0]      o_reg_rdata,
  // conversion samples in
  input  wire                          i_sample_valid,
  input  wire [1:0]                    i_sample_chan,
  input  wire [`OPAFC_SAMPLE_W-1:0]    i_sample_data,
  // per-channel pattern values, channel 0 in the low bits
  input  wire [4*`OPAFC_PAT_W-1:0]     i_per_channel_pattern_value,
  // packets out
  output wire                          o_packet_valid,
  output wire [1:0]                    o_packet_chan,
  output wire [`OPAFC_WORD_W-1:0]      o_packet_data,
  // decoded configuration
  output wire                          o_fixed_pattern_output_enable,
  output wire                          o_packet_size_24,
  output wire                          o_packet_size_reserved,
  output wire [2:0]                    o_packet_layout,
  output wire                          o_averaging_enable,
  output wire [3:0]                    o_averaging_count_select,
  output wire [`OPAFC_COUNT_W-1:0]     o_averaging_count,
  output wire [3:0]                    o_auto_gain_ranging
);

  // ****************************************************************
  // functions
  // ****************************************************************
  // last count index of an averaging run: two to the code plus one, less 1
  function [`OPAFC_CNT_W-1:0] last_index;
    input [3:0] code;
    reg   [`OPAFC_COUNT_W-1:0] full;
    begin
      // five-bit shift amount so code 15 gives 16, not a wrapped 0
      full       = {{(`OPAFC_COUNT_W-1){1'b0}}, 1'b1} << ({1'b0, code} + 5'h01);
      last_index = full[`OPAFC_CNT_W-1:0] - {{(`OPAFC_CNT_W-1){1'b0}}, 1'b1};
    end
  endfunction

  // average as a 24-bit word: 16 integer bits then 8 fraction bits
  function [`OPAFC_WORD_W-1:0] avg_word;
    input signed [`OPAFC_ACC_W-1:0] sum;
    input        [3:0]              code;
    reg   signed [`OPAFC_ACC_W+`OPAFC_FRAC_W-1:0] wide;
    begin
      wide     = {sum, {`OPAFC_FRAC_W{1'b0}}};
      wide     = wide >>> ({1'b0, code} + 5'h01);
      avg_word = wide[`OPAFC_WORD_W-1:0];
    end
  endfunction

  // sign extend a raw sample to accumulator width
  function signed [`OPAFC_ACC_W-1:0] widen;
    input [`OPAFC_SAMPLE_W-1:0] s;
    begin
      widen = {{(`OPAFC_ACC_W-`OPAFC_SAMPLE_W){s[`OPAFC_SAMPLE_W-1]}}, s};
    end
  endfunction

  // ****************************************************************
  // register storage
  // ****************************************************************
  reg [`OPAFC_DATA_W-1:0] output_frame_format;
  reg [`OPAFC_DATA_W-1:0] averaging_control;
  reg [`OPAFC_DATA_W-1:0] gain_ranging_enables;

  wire wr_frame = i_reg_wr && (i_reg_addr == `OPAFC_ADDR_FRAME_FORMAT);
  wire wr_avg   = i_reg_wr && (i_reg_addr == `OPAFC_ADDR_AVG_CONTROL);
  wire wr_gain  = i_reg_wr && (i_reg_addr == `OPAFC_ADDR_GAIN_ENABLES);

  // writes land the cycle after the strobe; reserved bits never store
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      output_frame_format  <= `OPAFC_RST_FRAME_FORMAT; // RULE11 RULE3
      averaging_control    <= `OPAFC_RST_AVG_CONTROL; // RULE6
      gain_ranging_enables <= `OPAFC_RST_GAIN_ENABLES; // RULE10
    end else begin
      if (wr_frame) begin
        output_frame_format <= i_reg_wdata & `OPAFC_MASK_FRAME_FORMAT; // RULE13
      end
      if (wr_avg) begin
        averaging_control <= i_reg_wdata & `OPAFC_MASK_AVG_CONTROL; // RULE13
      end
      if (wr_gain) begin
        gain_ranging_enables <= i_reg_wdata & `OPAFC_MASK_GAIN_ENABLES; // RULE13
      end
    end
  end

  // ****************************************************************
  // register read port
  // ****************************************************************
  reg [`OPAFC_DATA_W-1:0] next_rdata;

  // unmapped addresses read zero; stored values already hold reserved zeros
  always @* begin
    case (i_reg_addr)
      `OPAFC_ADDR_FRAME_FORMAT: next_rdata = output_frame_format;
      `OPAFC_ADDR_AVG_CONTROL:  next_rdata = averaging_control;
      `OPAFC_ADDR_GAIN_ENABLES: next_rdata = gain_ranging_enables;
      default:                  next_rdata = `OPAFC_READ_UNMAPPED;
    endcase
  end

  // read data stand only in the cycle after the read strobe
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_reg_rdata <= `OPAFC_READ_UNMAPPED;
    end else if (i_reg_rd) begin
      o_reg_rdata <= next_rdata; // RULE13
    end else begin
      o_reg_rdata <= `OPAFC_READ_UNMAPPED;
    end
  end

  // ****************************************************************
  // field decode
  // ****************************************************************
  wire [1:0] size_code = output_frame_format[`OPAFC_SIZE_MSB:
                                             `OPAFC_SIZE_LSB];
  wire       avg_on    = averaging_control[`OPAFC_AVG_EN_BIT];
  wire [3:0] avg_sel   = averaging_control[`OPAFC_AVG_SEL_MSB:
                                           `OPAFC_AVG_SEL_LSB];

  // reserved size codes fall back to 24 bits so the bus never goes idle;
  // the host is expected never to write code 10
  assign o_packet_size_24 = (size_code != `OPAFC_SIZE_16); // RULE12 RULE4
  assign o_packet_size_reserved = (size_code == `OPAFC_SIZE_RSV_A) ||
                                  (size_code == `OPAFC_SIZE_RSV_B); // RULE12

  assign o_fixed_pattern_output_enable =
    output_frame_format[`OPAFC_FIXED_PAT_BIT];
  assign o_averaging_enable       = avg_on; // RULE6
  assign o_averaging_count_select = avg_sel;
  // count is two to the code plus one, 2 up to 65536
  assign o_averaging_count = {{(`OPAFC_COUNT_W-1){1'b0}}, 1'b1}
                             << ({1'b0, avg_sel} + 5'h01); // RULE9
  assign o_auto_gain_ranging =
    gain_ranging_enables[`OPAFC_GAIN_EN_MSB:`OPAFC_GAIN_EN_LSB]; // RULE10

  // layout selector seen by the serialiser: pattern, averaging, size
  assign o_packet_layout = {o_fixed_pattern_output_enable, avg_on,
                            o_packet_size_24}; // RULE5

  // ****************************************************************
  // per-channel averaging
  // ****************************************************************
  reg signed [`OPAFC_ACC_W-1:0] acc [0:`OPAFC_CHANNELS-1];
  reg        [`OPAFC_CNT_W-1:0] cnt [0:`OPAFC_CHANNELS-1];

  // a run in flight is dropped whenever averaging is off or the count
  // select register is written, so a ratio change mid-run cannot mix
  // two ratios into one result
  wire avg_flush = !avg_on || wr_avg;

  wire signed [`OPAFC_ACC_W-1:0] sum_now =
    acc[i_sample_chan] + widen(i_sample_data);
  wire run_done = (cnt[i_sample_chan] == last_index(avg_sel)); // RULE9

  integer ch;

  // each channel keeps its own sum and count
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      for (ch = 0; ch < `OPAFC_CHANNELS; ch = ch + 1) begin
        acc[ch] <= {`OPAFC_ACC_W{1'b0}};
        cnt[ch] <= {`OPAFC_CNT_W{1'b0}};
      end
    end else if (avg_flush) begin
      for (ch = 0; ch < `OPAFC_CHANNELS; ch = ch + 1) begin
        acc[ch] <= {`OPAFC_ACC_W{1'b0}};
        cnt[ch] <= {`OPAFC_CNT_W{1'b0}};
      end
    end else if (i_sample_valid) begin
      if (run_done) begin
        acc[i_sample_chan] <= {`OPAFC_ACC_W{1'b0}};
        cnt[i_sample_chan] <= {`OPAFC_CNT_W{1'b0}};
      end else begin
        acc[i_sample_chan] <= sum_now; // RULE8
        cnt[i_sample_chan] <= cnt[i_sample_chan] +
                              {{(`OPAFC_CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // ****************************************************************
  // word stage
  // ****************************************************************
  reg                      word_valid;
  reg [1:0]                word_chan;
  reg [`OPAFC_WORD_W-1:0]  word;
  reg                      next_word_valid;
  reg [`OPAFC_WORD_W-1:0]  next_word;

  // plain mode passes each sample; averaging emits one word per run
  always @* begin
    next_word_valid = 1'b0;
    next_word       = {i_sample_data, {`OPAFC_FRAC_W{1'b0}}};
    if (i_sample_valid) begin
      if (!avg_on) begin
        next_word_valid = 1'b1; // RULE6
      end else if (!wr_avg && run_done) begin
        next_word_valid = 1'b1; // RULE8
        next_word       = avg_word(sum_now, avg_sel);
      end
    end
  end

  // one register stage keeps the adder off the packet path
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      word_valid <= 1'b0;
      word_chan  <= 2'h0;
      word       <= {`OPAFC_WORD_W{1'b0}};
    end else begin
      word_valid <= next_word_valid;
      if (next_word_valid) begin
        word_chan <= i_sample_chan;
        word      <= next_word;
      end
    end
  end

  // ****************************************************************
  // packet source and size
  // ****************************************************************
  // pattern and size take effect on the next word formatted
  opafc_packet_mux u_packet_mux (
    .i_ref_clk                     (i_ref_clk),
    .i_rst                         (i_rst),
    .i_fixed_pattern_output_enable (o_fixed_pattern_output_enable),
    .i_size_24                     (o_packet_size_24),
    .i_per_channel_pattern_value   (i_per_channel_pattern_value),
    .i_word_valid                  (word_valid),
    .i_word_chan                   (word_chan),
    .i_word                        (word),
    .o_packet_valid                (o_packet_valid),
    .o_packet_chan                 (o_packet_chan),
    .o_packet_data                 (o_packet_data)
  ); // RULE1 RULE2 RULE5

endmodule

/* File: opafc_config_regs_checker.sv */
// assertions on the ports of the configuration register block
// assumes one clock, i_ref_clk, and asynchronous active-high i_rst
// ******************************************************************
// port checker
// ******************************************************************
module opafc_config_regs_checker (
  // clock and reset
  input logic        i_ref_clk,
  input logic        i_rst,
  // register port
  input logic [7:0]  i_reg_addr,
  input logic [7:0]  i_reg_wdata,
  input logic        i_reg_wr,
  input logic        i_reg_rd,
  input logic [7:0]  o_reg_rdata,
  // samples and packets
  input logic        i_sample_valid,
  input logic [15:0] i_sample_data,
  input logic        o_packet_valid,
  input logic [23:0] o_packet_data,
  // decoded configuration
  input logic        o_fixed_pattern_output_enable,
  input logic        o_packet_size_24,
  input logic        o_packet_size_reserved,
  input logic [2:0]  o_packet_layout,
  input logic        o_averaging_enable,
  input logic [3:0]  o_averaging_count_select,
  input logic [16:0] o_averaging_count,
  input logic [3:0]  o_auto_gain_ranging
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  // bus steps; a plain sample excludes writes, which may flush or resize
  sequence s_wr(a); i_reg_wr && i_reg_addr == a; endsequence
  sequence s_rd(a); i_reg_rd && i_reg_addr == a; endsequence
  sequence s_plain;
    i_sample_valid && !i_reg_wr && !o_averaging_enable
      && !o_fixed_pattern_output_enable;
  endsequence
  property p_idle_rd; !i_reg_rd |=> o_reg_rdata == 8'h00; endproperty
  property p_rd_frame;
    s_rd(8'h26) |=> o_reg_rdata[7:2] == {5'h00,
      $past(o_fixed_pattern_output_enable)};
  endproperty
  property p_rd_avg;
    s_rd(8'h27) |=> o_reg_rdata == {$past(o_averaging_enable), 3'h0,
      $past(o_averaging_count_select)};
  endproperty
  property p_wr_avg;
    s_wr(8'h27) |=> o_averaging_enable == $past(i_reg_wdata[7])
      && o_averaging_count_select == $past(i_reg_wdata[3:0]);
  endproperty
  property p_wr_frame;
    s_wr(8'h26) |=> o_packet_size_24 == ($past(i_reg_wdata[1:0]) != 2'h0)
      && o_packet_size_reserved == $past(i_reg_wdata[1])
      && o_fixed_pattern_output_enable == $past(i_reg_wdata[2]);
  endproperty
  property p_wr_gain;
    s_wr(8'h28) |=> o_auto_gain_ranging == $past(i_reg_wdata[3:0]);
  endproperty
  property p_count;
    o_averaging_count == (17'h00001 << (o_averaging_count_select + 1));
  endproperty
  property p_layout;
    o_packet_layout == {o_fixed_pattern_output_enable,
      o_averaging_enable, o_packet_size_24};
  endproperty
  property p_plain;
    s_plain |-> ##2 o_packet_valid && o_packet_data == (o_packet_size_24 ?
      {$past(i_sample_data, 2), 8'h00} : {8'h00, $past(i_sample_data, 2)});
  endproperty
  property p_src; o_packet_valid |-> $past(i_sample_valid, 2); endproperty
  a_idle_rd: assert property (p_idle_rd) else $error("stray read data");
  a_rd_frame: assert property (p_rd_frame) else $error("frame read bad");
  a_rd_avg: assert property (p_rd_avg) else $error("avg read bad");
  a_wr_avg: assert property (p_wr_avg) else $error("avg write bad");
  a_wr_frame: assert property (p_wr_frame) else $error("size bad");
  a_wr_gain: assert property (p_wr_gain) else $error("gain bad");
  a_count: assert property (p_count) else $error("count bad");
  a_layout: assert property (p_layout) else $error("layout bad");
  a_plain: assert property (p_plain) else $error("plain packet bad");
  a_src: assert property (p_src) else $error("packet without sample");
endmodule

bind opafc_config_regs opafc_config_regs_checker i_chk (
  .i_ref_clk, .i_rst, .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd,
  .o_reg_rdata, .i_sample_valid, .i_sample_data, .o_packet_valid,
  .o_packet_data, .o_fixed_pattern_output_enable, .o_packet_size_24,
  .o_packet_size_reserved, .o_packet_layout, .o_averaging_enable,
  .o_averaging_count_select, .o_averaging_count, .o_auto_gain_ranging
);

/* File: opafc_host_model.sv */
// host controller model driving the register port
// assumes the slave never stalls and read data follow one cycle later
// ******************************************************************
// host model
// ******************************************************************
module opafc_host_model (
  input  logic       i_ref_clk,
  output logic [7:0] o_reg_addr,
  output logic [7:0] o_reg_wdata,
  output logic       o_reg_wr,
  output logic       o_reg_rd
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle bus at time zero
  initial begin
    o_reg_addr = 8'h00;
    o_reg_wdata = 8'h00;
    o_reg_wr = 1'b0;
    o_reg_rd = 1'b0;
  end
  // released lines show the inverse so stale values never look valid
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (a == 8'h26 && v[1:0] == 2'h2) v[0] = 1'b1;
    @(posedge i_ref_clk);
    o_reg_wr <= 1'b1;
    o_reg_addr <= a;
    o_reg_wdata <= v;
    @(posedge i_ref_clk);
    o_reg_wr <= 1'b0;
    o_reg_addr <= ~a;
    o_reg_wdata <= ~v;
  endtask
  task automatic reg_read(input logic [7:0] a);
    @(posedge i_ref_clk);
    o_reg_rd <= 1'b1;
    o_reg_addr <= a;
    @(posedge i_ref_clk);
    o_reg_rd <= 1'b0;
    o_reg_addr <= ~a;
  endtask
  // enable is dropped in the same write that loads a new count select
  task automatic avg_config(input logic en, input logic [3:0] sel);
    reg_write(8'h27, {4'h0, sel});
    if (en) reg_write(8'h27, {4'h8, sel});
  endtask
endmodule

/* File: tb_output_packet_and_averaging_config.sv */
// self-checking bench for the configuration register block
// assumes the bound checker and the host model in the same compile
// ******************************************************************
// bench top
// ******************************************************************
module tb_output_packet_and_averaging_config;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_ref_clk = 1'b0, i_rst = 1'b1, i_reg_wr, i_reg_rd;
  logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata;
  logic i_sample_valid = 1'b0;
  logic [1:0] i_sample_chan = 2'h0, o_packet_chan;
  logic [15:0] i_sample_data = 16'h0000, lfsr = 16'h001B;
  logic [127:0] i_per_channel_pattern_value = 128'h0;
  logic o_packet_valid, o_fixed_pattern_output_enable, o_packet_size_24;
  logic o_packet_size_reserved, o_averaging_enable, rd_d = 1'b0;
  logic [23:0] o_packet_data, e;
  logic [2:0] o_packet_layout;
  logic [3:0] o_averaging_count_select, o_auto_gain_ranging;
  logic [16:0] o_averaging_count;
  logic [7:0] rd_q[$], f;
  logic [25:0] pk_q[$];
  logic [7:0] f_list[4] = '{8'h00, 8'h01, 8'h05, 8'h04};
  logic signed [40:0] acc[2];
  int errors = 0, check_count = 0, cyc = 0, n[2];
  opafc_config_regs i_dut (.*);
  opafc_host_model i_host (.i_ref_clk, .o_reg_addr(i_reg_addr),
    .o_reg_wdata(i_reg_wdata), .o_reg_wr(i_reg_wr), .o_reg_rd(i_reg_rd));
  always #2.5 i_ref_clk = ~i_ref_clk;
  function automatic logic [15:0] rnd(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic compare(input string nm, input logic [25:0] x, y);
    check_count++;
    if (x !== y) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, x, y);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic rd(input logic [7:0] a, x);
    rd_q.push_back(x);
    i_host.reg_read(a);
  endtask
  // a sample stays valid for back-to-back runs until stop
  task automatic smp(input logic [1:0] c, input bit emit, input logic [23:0] x);
    if (emit) pk_q.push_back({c, x});
    @(posedge i_ref_clk);
    i_sample_valid <= 1'b1;
    i_sample_chan <= c;
    i_sample_data <= lfsr;
  endtask
  task automatic stop();
    @(posedge i_ref_clk);
    i_sample_valid <= 1'b0;
    i_sample_data <= ~i_sample_data;
    repeat (4) @(posedge i_ref_clk);
  endtask
  // read data stand one cycle after the strobe; packets match in order
  always @(posedge i_ref_clk) begin
    cyc <= cyc + 1;
    rd_d <= i_reg_rd;
    if (rd_d) compare("rdata", rd_q.pop_front(), o_reg_rdata);
    if (o_packet_valid)
      compare("packet", pk_q.size() ? pk_q.pop_front() : 'x,
        {o_packet_chan, o_packet_data});
    if (cyc == 20000) begin
      errors++;
      results();
    end
  end
  // main sequence: reset values, masks, counts, packets, averaging
  initial begin
    repeat (10) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    rd(8'h26, 8'h01);
    rd(8'h27, 8'h00);
    rd(8'h28, 8'h0F);
    rd(8'h29, 8'h00);
    compare("layout", 3'h1, o_packet_layout);
    compare("count", 17'h2, o_averaging_count);
    for (int a = 8'h26; a < 8'h29; a++) i_host.reg_write(a[7:0], 8'hFF);
    rd(8'h26, 8'h07);
    rd(8'h27, 8'h8F);
    #1 compare("reserved", 1'b1, o_packet_size_reserved);
    for (int i = 0; i < 4; i++) begin
      lfsr = rnd(lfsr);
      i_host.reg_write(8'h28, lfsr[7:0]);
      rd(8'h28, {4'h0, lfsr[3:0]});
    end
    for (int c = 0; c < 16; c++) begin
      i_host.avg_config(1'b1, c[3:0]);
      #1 compare("count", 17'h1 << (c + 1), o_averaging_count);
    end
    i_host.avg_config(1'b0, 4'h0);
    foreach (f_list[k]) begin
      f = f_list[k];
      i_host.reg_write(8'h26, f);
      i_per_channel_pattern_value <= {8{lfsr}} ^ {k, 96'h0};
      repeat (2) @(posedge i_ref_clk);
      for (int i = 0; i < 8; i++) begin
        lfsr = rnd(lfsr);
        e = i_per_channel_pattern_value[lfsr[1:0]*32+8 +: 24];
        if (!f[2]) e = {lfsr, 8'h00};
        if (!f[0]) e = {8'h00, e[23:8]};
        smp(lfsr[1:0], 1'b1, e);
      end
      stop();
    end
    i_host.reg_write(8'h26, 8'h01);
    for (int s = 0; s < 3; s++) begin
      i_host.avg_config(1'b1, s[3:0]);
      acc = '{0, 0};
      n = '{0, 0};
      for (int i = 0; i < 4 << s; i++) begin
        lfsr = rnd(lfsr);
        acc[i % 2] += $signed(lfsr);
        n[i % 2]++;
        e = ((acc[i % 2] <<< 8) >>> (s + 1));
        smp(2'(i % 2), n[i % 2] == 2 << s, e);
      end
      stop();
    end
    compare("left", 0, pk_q.size());
    results();
  end
endmodule
